// File: hw/sps_baud.sv
// Master bit-rate divider: one tick per half serial clock period
`timescale 1ns/1ps
module sps_baud #(
    parameter int CW = 7
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_run,
    input  wire logic [2:0] i_rate,
    // Tick
    output logic            o_tick
);
    logic [CW-1:0] cnt;
    wire  [CW-1:0] half;
    wire           wrap;

    // Divisor 2^(rate+1), so a half period is 2^rate cycles
    assign half = CW'(1) << i_rate;
    assign wrap = (cnt == half - CW'(1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= wrap ? '0 : cnt + CW'(1);
            o_tick <= wrap;
        end
    end
endmodule

// File: hw/sps_sync.sv
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/1ps
module sps_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= RST;
            o_q  <= RST;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

// File: hw/sps_top.sv
// Byte-wide full-duplex serial port, master or slave
//
// Operation
// - Each exchange shifts one bit out and one bit in per serial clock
// - master_select set gives master operation, cleared gives slave
// - Master: data write with idle shifter and rate field 1 to 6 loads it and starts clocking
// - On completion set transfer_done_flag and copy received byte together
// - Status read with done set, then data read, clears transfer_done_flag
// - Slave: full byte received goes to receive register, flag set
// - Slave: late data write means old shifter content is sent
// - clock_idle_level sets idle clock; both bits pick one of four formats
// - Phase clear: slave drives MSB early, select fall starts exchange
// - Phase set: first clock edge starts exchange, select may stay low
// - Master, select low, pin enabled: mode fault, disable, drop master
// - select_pin_disable set: select pin never raises mode_fault_flag
// - Status read with fault, then control write, clears mode_fault_flag
// - Data write during exchange sets write_collision_flag, exchange goes on
// - Status access then data access clears write_collision_flag
// - Bytes after an uncleared done are dropped, no overrun flag
// - Done drives transmit request; fault drives error request if pin enabled
// - Unselected slave leaves the shared lines undriven
// - Master makes exactly eight clocks per byte, MSB first
// - Master clock is system clock over 4 to 128 by rate field
`timescale 1ns/1ps
module sps_top (
    // System clock and reset
    input  wire logic               I_CLK_SYS,
    input  wire logic               I_RESETN,
    // Link sampling clock
    input  wire logic               I_CLK_LINK,
    // Software access strobes
    input  wire logic               I_CTRL_WR,
    input  wire sps_pkg::sps_ctrl_t I_CTRL_WDATA,
    input  wire logic               I_STAT_RD,
    input  wire logic               I_DATA_WR,
    input  wire logic [7:0]         I_DATA_WDATA,
    input  wire logic               I_DATA_RD,
    // Register contents
    output sps_pkg::sps_ctrl_t      O_CTRL,
    output sps_pkg::sps_stat_t      O_STATUS,
    output logic [7:0]              O_RX_DATA,
    // Interrupt requests
    output logic                    O_TX_IRQ,
    output logic                    O_ERR_IRQ,
    // Serial clock pin
    input  wire logic               I_SCK,
    output logic                    O_SCK,
    output logic                    O_SCK_OE_N,
    // Master-out pin
    input  wire logic               I_MOSI,
    output logic                    O_MOSI,
    output logic                    O_MOSI_OE_N,
    // Master-in pin
    input  wire logic               I_MISO,
    output logic                    O_MISO,
    output logic                    O_MISO_OE_N,
    // Select pin
    input  wire logic               I_SS_N
);
    import sps_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic rate_ok(input sps_ctrl_t c);
        logic [2:0] r;
        r = {c.rate2, c.rate1, c.rate0};
        return (r >= RATE_MIN) && (r <= RATE_MAX);
    endfunction

    // ------------------------------------------------------------
    // System domain state
    // ------------------------------------------------------------
    sps_ctrl_t  ctrl;
    sps_stat_t  stat;
    sps_mst_t   m_state;
    logic [7:0] rx;
    logic [7:0] sh;
    logic [3:0] edge_n;
    logic       sck_q;
    logic       mosi_q;
    logic       mst_oe_n;
    logic       tx_irq;
    logic       err_irq;
    logic       done_arm;
    logic       write_collision_flag_arm;
    logic       mode_fault_flag_arm;
    logic [7:0] tx_hold;
    logic       tx_tgl;
    logic       ldone_d;
    logic [7:0] rsh;
    logic [1:0] cap_d;
    logic [1:0] fin_d;
    // Link domain state
    sps_slv_t   l_state;
    logic [7:0] lsh;
    logic [7:0] rx_link;
    logic [2:0] l_cnt;
    logic       l_busy;
    logic       done_tgl;
    logic       miso_q;
    logic       miso_oe_n;
    logic       lvl_d;
    logic       ss_d;
    logic       tgl_d;
    logic       pend;

    // ------------------------------------------------------------
    // Crossings into the system domain
    // ------------------------------------------------------------
    logic miso_s;
    logic ss_n_s;
    logic lbusy_s;
    logic ldone_s;

    sps_sync #(.W(4), .RST(4'b0100)) u_sync_sys (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RESETN),
        .i_d     ({I_MISO, I_SS_N, l_busy, done_tgl}),
        .o_q     ({miso_s, ss_n_s, lbusy_s, ldone_s})
    );

    // ------------------------------------------------------------
    // System domain decode
    // ------------------------------------------------------------
    wire tick;
    wire m_run    = (m_state == M_RUN);
    wire mst_mode = ctrl.enable & ctrl.master;
    wire slv_mode = ctrl.enable & ~ctrl.master;
    // Fault ignores the pin entirely when it is freed
    wire mode_fault_flag_evt = mst_mode & ~ctrl.select_pin_disable & ~ss_n_s;
    wire busy     = m_run | (|fin_d) | (slv_mode & lbusy_s);
    wire write_collision_flag_evt = I_DATA_WR & busy;
    wire m_start  = I_DATA_WR & mst_mode & ~busy
                  & rate_ok(ctrl) & ~mode_fault_flag_evt;
    wire m_fin    = m_run & tick & (edge_n == EDGE_LAST);
    wire m_abort  = m_run & (mode_fault_flag_evt | ~mst_mode);
    wire samp     = tick & (ctrl.clock_sample_phase ? edge_n[0] : ~edge_n[0]);
    wire drv      = tick & (ctrl.clock_sample_phase ? ~edge_n[0] : edge_n[0]);
    wire [7:0] next_sh = samp ? {sh[6:0], miso_s} : sh;
    // Line passes two flops, so capture two cycles after the edge
    wire [7:0] next_rsh = cap_d[1] ? {rsh[6:0], miso_s} : rsh;
    wire [3:0] edge_next = edge_n + {3'b000, tick};
    wire slv_done = ldone_s ^ ldone_d;
    wire done_evt = fin_d[1] | slv_done;
    // Receive register frozen while the flag is still up
    wire rx_load  = done_evt & ~stat.done;
    wire done_clr = I_DATA_RD & done_arm;
    wire write_collision_flag_clr = (I_DATA_RD | I_DATA_WR) & write_collision_flag_arm;
    wire mode_fault_flag_clr = I_CTRL_WR & mode_fault_flag_arm;
    // Hardware set wins over a clearing access in the same cycle
    wire next_done = done_evt | (stat.done & ~done_clr);
    wire next_write_collision_flag = write_collision_flag_evt | (stat.write_collision_flag & ~write_collision_flag_clr);
    wire next_mode_fault_flag = mode_fault_flag_evt | (stat.mode_fault_flag & ~mode_fault_flag_clr);
    wire slv_wr   = I_DATA_WR & ~ctrl.master & ~busy;

    sps_ctrl_t wr_ctrl;
    sps_ctrl_t next_ctrl;
    always_comb begin
        wr_ctrl = I_CTRL_WR ? I_CTRL_WDATA : ctrl;
        // Enable stays off until the fault has been cleared first
        if (I_CTRL_WR && stat.mode_fault_flag)
            wr_ctrl.enable = 1'b0;
        next_ctrl = wr_ctrl;
        if (mode_fault_flag_evt) begin
            next_ctrl.enable = 1'b0;
            next_ctrl.master = 1'b0;
        end
    end

    sps_baud #(.CW(DIV_W)) u_baud (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RESETN),
        .i_run   (m_run & ~m_fin),
        .i_rate  ({ctrl.rate2, ctrl.rate1, ctrl.rate0}),
        .o_tick  (tick)
    );

    // ------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl     <= sps_ctrl_t'(CTRL_RST);
            stat     <= sps_stat_t'(STAT_RST);
            rx       <= DATA_RST;
            done_arm <= 1'b0;
            write_collision_flag_arm <= 1'b0;
            mode_fault_flag_arm <= 1'b0;
            tx_irq   <= 1'b0;
            err_irq  <= 1'b0;
            ldone_d  <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            stat.done <= next_done;
            stat.write_collision_flag <= next_write_collision_flag;
            stat.mode_fault_flag <= next_mode_fault_flag;
            ldone_d   <= ldone_s;
            if (rx_load)
                rx <= fin_d[1] ? next_rsh : rx_link;
            if (I_STAT_RD) begin
                done_arm <= stat.done;
                mode_fault_flag_arm <= stat.mode_fault_flag;
            end else begin
                done_arm <= done_arm & ~I_DATA_RD;
                mode_fault_flag_arm <= mode_fault_flag_arm & ~I_CTRL_WR;
            end
            write_collision_flag_arm <= I_STAT_RD | (write_collision_flag_arm & ~I_DATA_RD & ~I_DATA_WR);
            tx_irq   <= next_done;
            err_irq  <= next_mode_fault_flag & ~next_ctrl.select_pin_disable;
        end
    end

    // ------------------------------------------------------------
    // Master shifter
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            m_state  <= M_IDLE;
            sh       <= DATA_RST;
            edge_n   <= '0;
            sck_q    <= 1'b0;
            mosi_q   <= 1'b0;
            mst_oe_n <= 1'b1;
            rsh      <= DATA_RST;
            cap_d    <= '0;
            fin_d    <= '0;
        end else begin
            mst_oe_n <= ~mst_mode;
            cap_d    <= {cap_d[0], samp & m_run};
            fin_d    <= {fin_d[0], m_fin};
            rsh      <= next_rsh;
            case (m_state)
                M_IDLE: begin
                    sck_q <= ctrl.clock_idle_level;
                    if (m_start) begin
                        m_state <= M_RUN;
                        sh      <= I_DATA_WDATA;
                        edge_n  <= '0;
                        if (!ctrl.clock_sample_phase)
                            mosi_q <= I_DATA_WDATA[7];
                    end
                end
                M_RUN: begin
                    if (m_abort || m_fin) begin
                        m_state <= M_IDLE;
                        sck_q   <= ctrl.clock_idle_level;
                    end else if (tick) begin
                        edge_n <= edge_n + 4'h1;
                        sh     <= next_sh;
                        sck_q  <= ctrl.clock_idle_level ^ ~edge_n[0];
                        if (drv)
                            mosi_q <= sh[7];
                    end
                end
                default: m_state <= M_IDLE;
            endcase
        end
    end

    // Slave transmit byte handed to the link side by toggle
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tx_hold <= DATA_RST;
            tx_tgl  <= 1'b0;
        end else if (slv_wr) begin
            tx_hold <= I_DATA_WDATA;
            tx_tgl  <= ~tx_tgl;
        end
    end

    // ------------------------------------------------------------
    // Link domain: slave shifter on the sampling clock
    // ------------------------------------------------------------
    logic sck_s, ss_s, mosi_s, en_s, mst_s, clock_idle_level_s, clock_sample_phase_s, select_pin_disable_s, tgl_s;

    sps_sync #(.W(9), .RST(9'b0_1000_0000)) u_sync_link (
        .i_clk   (I_CLK_LINK),
        .i_rst_n (I_RESETN),
        .i_d     ({I_SCK, I_SS_N, I_MOSI, ctrl.enable, ctrl.master,
                   ctrl.clock_idle_level, ctrl.clock_sample_phase, ctrl.select_pin_disable, tx_tgl}),
        .o_q     ({sck_s, ss_s, mosi_s, en_s, mst_s,
                   clock_idle_level_s, clock_sample_phase_s, select_pin_disable_s, tgl_s})
    );

    // Select pin only waivable in phase-set format
    wire l_sel   = en_s & ~mst_s & (~ss_s | (clock_sample_phase_s & select_pin_disable_s));
    wire sck_lvl = sck_s ^ clock_idle_level_s;
    wire l_lead  = sck_lvl & ~lvl_d;
    wire l_trail = ~sck_lvl & lvl_d;
    wire ss_fall = ~ss_s & ss_d;
    wire l_samp  = clock_sample_phase_s ? l_trail : l_lead;
    wire l_drv   = clock_sample_phase_s ? l_lead : l_trail;
    wire l_start = (l_state == S_IDLE) & l_sel
                 & (clock_sample_phase_s ? l_lead : ss_fall);
    wire tx_new  = tgl_s ^ tgl_d;
    // Late write leaves the previous shifter content in place
    wire [7:0] l_load = (pend | tx_new) ? tx_hold : lsh;
    wire [7:0] l_next = {lsh[6:0], mosi_s};

    always_ff @(posedge I_CLK_LINK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lvl_d <= 1'b0;
            ss_d  <= 1'b1;
            tgl_d <= 1'b0;
            pend  <= 1'b0;
        end else begin
            lvl_d <= sck_lvl;
            ss_d  <= ss_s;
            tgl_d <= tgl_s;
            pend  <= (pend | tx_new) & ~l_start;
        end
    end

    always_ff @(posedge I_CLK_LINK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            l_state   <= S_IDLE;
            lsh       <= DATA_RST;
            rx_link   <= DATA_RST;
            l_cnt     <= '0;
            l_busy    <= 1'b0;
            done_tgl  <= 1'b0;
            miso_q    <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            miso_oe_n <= ~l_sel;
            case (l_state)
                S_IDLE: begin
                    if (l_start) begin
                        l_state <= S_SHIFT;
                        l_busy  <= 1'b1;
                        lsh     <= l_load;
                        l_cnt   <= '0;
                        miso_q  <= l_load[7];
                    end
                end
                S_SHIFT: begin
                    if (!l_sel) begin
                        l_state <= S_IDLE;
                        l_busy  <= 1'b0;
                    end else if (l_samp) begin
                        lsh   <= l_next;
                        l_cnt <= l_cnt + 3'h1;
                        if (l_cnt == BIT_LAST) begin
                            rx_link  <= l_next;
                            done_tgl <= ~done_tgl;
                            l_state  <= S_IDLE;
                            l_busy   <= 1'b0;
                        end
                    end else if (l_drv) begin
                        miso_q <= lsh[7];
                    end
                end
                default: l_state <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_CTRL      = ctrl;
    assign O_STATUS    = stat;
    assign O_RX_DATA   = rx;
    assign O_TX_IRQ    = tx_irq;
    assign O_ERR_IRQ   = err_irq;
    assign O_SCK       = sck_q;
    assign O_SCK_OE_N  = mst_oe_n;
    assign O_MOSI      = mosi_q;
    assign O_MOSI_OE_N = mst_oe_n;
    assign O_MISO      = miso_q;
    assign O_MISO_OE_N = miso_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [3:0] lead_cnt;
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN)
            lead_cnt <= '0;
        else if (m_start)
            lead_cnt <= '0;
        else if (m_run && tick && !edge_n[0])
            lead_cnt <= lead_cnt + 4'h1;
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);

    a_mode_fault_flag_disable: assert property ($rose(stat.mode_fault_flag) |-> !ctrl.enable && !ctrl.master)
        else $error("mode fault left port enabled");
    a_select_pin_disable_no_fault: assert property (ctrl.select_pin_disable && !stat.mode_fault_flag |=> !stat.mode_fault_flag)
        else $error("fault raised with pin disabled");
    a_irq_map: assert property (O_TX_IRQ == stat.done
                                && O_ERR_IRQ == (stat.mode_fault_flag && !ctrl.select_pin_disable))
        else $error("interrupt request mismatch");
    a_done_rx: assert property (fin_d[1] && !stat.done |=> stat.done && rx == $past(next_rsh))
        else $error("done without received byte");
    a_write_collision_flag_keep: assert property (write_collision_flag_evt && m_run && !m_fin && !m_abort
                                  |=> stat.write_collision_flag && m_run && edge_n == $past(edge_next))
        else $error("collision disturbed exchange");
    a_done_clear: assert property (I_STAT_RD && stat.done && !I_DATA_RD
                                   ##1 I_DATA_RD && !I_STAT_RD && !done_evt
                                   |=> !stat.done)
        else $error("done flag not cleared");
    a_mode_fault_flag_clear: assert property (I_STAT_RD && stat.mode_fault_flag && !I_CTRL_WR
                                   ##1 I_CTRL_WR && !I_STAT_RD && !mode_fault_flag_evt
                                   |=> !stat.mode_fault_flag && !ctrl.enable)
        else $error("fault flag not cleared");
    a_eight_clocks: assert property (m_fin |-> lead_cnt == LEADS)
        else $error("wrong serial clock count");
    a_sck_idle: assert property (!m_run && $past(!m_run) && $stable(ctrl.clock_idle_level)
                                 |-> O_SCK == ctrl.clock_idle_level)
        else $error("serial clock not at idle level");
    a_miso_hiz: assert property (@(posedge I_CLK_LINK) disable iff (!I_RESETN)
                                 !l_sel |=> O_MISO_OE_N)
        else $error("unselected slave drives line");

    c_master_byte: cover property (m_fin);
    c_slave_byte:  cover property (slv_done);
    c_mode_fault:  cover property ($rose(stat.mode_fault_flag));
    c_collision:   cover property ($rose(stat.write_collision_flag));
endmodule

// File: inc/sps_pkg.sv
// Package: shared types and constants of the serial port block
package sps_pkg;

    // ------------------------------------------------------------
    // Control and status layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic rate2;
        logic enable;
        logic select_pin_disable;
        logic master;
        logic clock_idle_level;
        logic clock_sample_phase;
        logic rate1;
        logic rate0;
    } sps_ctrl_t;

    typedef struct packed {
        logic       done;
        logic       write_collision_flag;
        logic       sserr;
        logic       mode_fault_flag;
        logic [3:0] rsvd;
    } sps_stat_t;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int         BYTE_W    = 8;
    localparam int         DIV_W     = 7;
    localparam logic [7:0] CTRL_RST  = 8'h14;
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [2:0] RATE_MIN  = 3'h1;
    localparam logic [2:0] RATE_MAX  = 3'h6;
    localparam logic [3:0] EDGE_LAST = 4'hF;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [3:0] LEADS     = 4'h8;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        M_IDLE = 1'b0,
        M_RUN  = 1'b1
    } sps_mst_t;

    typedef enum logic [0:0] {
        S_IDLE  = 1'b0,
        S_SHIFT = 1'b1
    } sps_slv_t;

endpackage

// File: verif/sps_slave_model.sv
// Partner model: external serial slave answering the port in master mode
`timescale 1ns/1ps
module sps_slave_model (
    // Serial lines
    input  wire logic       i_sck,
    input  wire logic       i_sel_n,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_tx,
    // Line back and byte seen
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] sh = 8'h00;
    logic       seen = 1'b0;
    // ------------------------------
    // Sample on rise, shift on fall
    // ------------------------------
    // Released line shows the inverse, so a stale bit never passes
    assign o_miso = i_sel_n ? ~sh[7] : sh[7];
    always @(negedge i_sel_n) begin
        sh = i_tx;
        seen = 1'b0;
    end
    always @(posedge i_sck)
        if (!i_sel_n) begin
            o_rx = {o_rx[6:0], i_mosi};
            seen = 1'b1;
        end
    // Idle-high format: the first fall leads, so it carries no shift
    always @(negedge i_sck)
        if (!i_sel_n && seen) sh = {sh[6:0], 1'b0};
endmodule

// File: verif/sps_top_test.sv
// Testbench: random and corner exchanges in master and slave mode
`timescale 1ns/1ps
module sps_top_test;
    import sps_pkg::*;
    logic       clk, lclk, rstn, cwr, srd, dwr, drd, sck_b, mosi_b, ss_n, sel_n;
    logic       tx_irq, err_irq, o_sck, sck_oe_n, o_mosi, mosi_oe_n, o_miso, miso_oe_n, pmiso;
    logic [7:0] wd, ptx, prx, m, tx, o_rx;
    sps_ctrl_t  cw, o_ctrl;
    sps_stat_t  o_stat;
    wire        sck_w  = sck_oe_n ? sck_b : o_sck;
    wire        mosi_w = mosi_oe_n ? mosi_b : o_mosi;
    wire        miso_w = miso_oe_n ? pmiso : o_miso;
    int         n_fail = 0, n_checks = 0, n_sck = 0, k;
    sps_top i_sps_top (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_CLK_LINK(lclk), .I_CTRL_WR(cwr),
        .I_CTRL_WDATA(cw), .I_STAT_RD(srd), .I_DATA_WR(dwr), .I_DATA_WDATA(wd), .I_DATA_RD(drd),
        .O_CTRL(o_ctrl), .O_STATUS(o_stat), .O_RX_DATA(o_rx), .O_TX_IRQ(tx_irq),
        .O_ERR_IRQ(err_irq), .I_SCK(sck_w), .O_SCK(o_sck), .O_SCK_OE_N(sck_oe_n),
        .I_MOSI(mosi_w), .O_MOSI(o_mosi), .O_MOSI_OE_N(mosi_oe_n), .I_MISO(miso_w),
        .O_MISO(o_miso), .O_MISO_OE_N(miso_oe_n), .I_SS_N(ss_n));
    sps_slave_model i_sps_slave_model (.i_sck(sck_w), .i_sel_n(sel_n), .i_mosi(mosi_w),
        .i_tx(ptx), .o_miso(pmiso), .o_rx(prx));
    // ----------------------
    // Clocks, tasks, watchdog
    // ----------------------
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    initial begin
        lclk = 0;
        #1.7;
        forever #3 lclk = ~lclk;
    end
    always @(posedge sck_w)
        if (!sck_oe_n) n_sck++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Strobes end with a spare cycle so back-to-back calls never retoggle
    task automatic ctrl_w(input logic [7:0] v);
        cwr = 1;
        cw = v;
        tick(1);
        cwr = 0;
        tick(1);
    endtask
    task automatic data_w(input logic [7:0] v);
        dwr = 1;
        wd = v;
        tick(1);
        dwr = 0;
        tick(1);
    endtask
    task automatic clr();
        srd = 1;
        tick(1);
        srd = 0;
        drd = 1;
        tick(1);
        drd = 0;
        tick(1);
    endtask
    // External master, idle-low clock, four system cycles per bit
    task automatic sframe(input logic [7:0] b);
        ss_n = 0;
        mosi_b = b[7];
        tick(3);
        chk(miso_oe_n, 0, "miso drive");
        for (int i = 7; i >= 0; i--) begin
            sck_b = 1;
            m[i] = miso_w;
            tick(2);
            sck_b = 0;
            mosi_b = b[(i + 7) % 8];
            tick(2);
        end
        ss_n = 1;
        tick(6);
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #3_000_000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        {cwr, srd, dwr, drd, sck_b, mosi_b, rstn} = '0;
        {ss_n, sel_n} = 2'b11;
        {cw, wd, ptx} = '0;
        k = $urandom(32'h1262);
        tick(12);
        rstn = 1;
        tick(1);
        chk(o_ctrl, CTRL_RST, "ctrl reset");
        chk(o_stat, STAT_RST, "stat reset");
        chk({tx_irq, err_irq, sck_oe_n, miso_oe_n}, 3, "pins reset");
        $display("test reset done");
        ctrl_w(8'h11);
        for (logic [2:0] r = 1; r <= 6; r++) begin
            ptx = (r == 1) ? 8'h80 : 8'($urandom);
            tx = (r == 1) ? 8'h01 : 8'($urandom);
            // Last rate runs the idle-high, late-sample format
            if (r == 6) ctrl_w({r[2], 5'b00111, r[1:0]});
            ctrl_w({r[2], 3'b101, {2{r == 3'h6}}, r[1:0]});
            sel_n = 0;
            n_sck = 0;
            data_w(tx);
            if (r == 1) data_w(8'hFF);
            for (k = 0; k < 3000 && o_stat.done !== 1'b1; k++)
                tick(1);
            tick(2);
            chk(k >= (16 << r) - 6 && k <= (16 << r) + 4, 1, "rate");
            chk(o_rx, ptx, "master rx");
            chk(prx, tx, "mosi byte");
            chk(n_sck[7:0], 8, "sck count");
            chk({tx_irq, o_stat.write_collision_flag}, {1'b1, r == 3'h1}, "irq write_collision_flag");
            clr();
            chk({o_stat.done, o_stat.write_collision_flag, tx_irq}, 0, "clear");
            sel_n = 1;
        end
        $display("test master done");
        ss_n = 0;
        tick(5);
        chk({o_stat.mode_fault_flag, err_irq, o_ctrl.enable, o_ctrl.master}, 4'hC, "fault");
        ss_n = 1;
        srd = 1;
        tick(1);
        srd = 0;
        ctrl_w(8'h11);
        chk({o_stat.mode_fault_flag, err_irq}, 0, "fault clear");
        ctrl_w(8'h31);
        ctrl_w(8'h71);
        ss_n = 0;
        tick(5);
        chk({o_stat.mode_fault_flag, err_irq, o_ctrl.enable}, 1, "pin off");
        ss_n = 1;
        $display("test fault done");
        ctrl_w(8'h00);
        ctrl_w(8'h40);
        tx = 8'($urandom);
        data_w(tx);
        sframe(8'h80);
        chk(m, tx, "slave tx");
        chk({o_rx, o_stat.done}, 9'h101, "slave rx");
        chk(miso_oe_n, 1, "miso release");
        sframe(8'($urandom));
        chk(m, 8'h80, "late write");
        chk(o_rx, 8'h80, "overrun");
        $display("test slave done");
        finish_test();
    end
endmodule
